// File: design/gsp_consts.svh
/*
 * Constants of the generator synchronizer pulse controller: scale factors,
 * time base, saturation value and the default settings.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef GSP_CONSTS_SVH
`define GSP_CONSTS_SVH

// ---------------------------------------------------------------
// Time base
// ---------------------------------------------------------------
`define GSP_CLK_PERIOD_NS 40
`define GSP_TICK_TIME_NS 5000000
`define GSP_TICK_CYCLES (`GSP_TICK_TIME_NS / `GSP_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Unit scaling (limit step to measurement step), rotation time numerator and saturation
// ---------------------------------------------------------------
`define GSP_VOLT_SCALE 32'h0000_0064
`define GSP_FREQ_SCALE 32'h0000_0064
`define GSP_ANG_SCALE 32'h0000_000A
`define GSP_ROT_NUM 32'h001E_8480
`define GSP_ROT_SAT 19'h1_1940

// ---------------------------------------------------------------
// Default settings, in setting units
// ---------------------------------------------------------------
`define GSP_DEF_VOLT_MAX 13'h00C8
`define GSP_DEF_FREQ_OVER 8'h14
`define GSP_DEF_FREQ_UNDER 8'h00
`define GSP_DEF_ANG_MAX 12'h3E8
`define GSP_DEF_SYNC_TIME 19'h0_EA60
`define GSP_DEF_VOLT_OFS 32'h0000_0000
`define GSP_DEF_FREQ_OFS 32'hFFFF_FC18
`define GSP_DEF_VOLT_SLOPE 12'h014
`define GSP_DEF_PULSE_MAX 19'h0_0258
`define GSP_DEF_PULSE_MIN 19'h0_0014
`define GSP_DEF_REST_MIN 19'h0_01F4

`endif

// File: design/gsp_pkg.sv
/*
 * Types of the generator synchronizer pulse controller.
 * Assumes nothing of its surroundings.
 */
package gsp_pkg;

	// ---------------------------------------------------------------
	// Adjustment pulse channel state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		GSP_IDLE = 2'b00,
		GSP_PULSE = 2'b01,
		GSP_REST = 2'b10
	} gsp_pulse_st_t;

	typedef logic [18:0] gsp_ticks_t;

endpackage : gsp_pkg

// File: design/gsp_sync_ctrl.sv
/*
 * Generator synchronizer permissive check and raise/lower pulse control.
 * Assumes the measured differences are presented synchronously to core_clk_in
 * and held stable; all settings are live ports that may change at any time.
 */
`timescale 1ns/100ps
`default_nettype none

`include "gsp_consts.svh"

// Contract
// [R1] Inhibit when voltage difference exceeds limit
// [R2] Inhibit when over-frequency slip exceeds limit
// [R3] Inhibit when under-frequency slip exceeds limit
// [R4] Cancel attempt after maximum synchronizing time
// [R5] Inhibit when angle difference exceeds limit
// [R6] Subtract voltage offset from magnitude difference
// [R7] Subtract frequency offset from frequency difference
// [R8] Get-errors captures differences when synchronized
// [R9] Voltage slope sets pulse length scaling
// [R10] Voltage pulse never longer than maximum
// [R11] Voltage pulse never shorter than minimum
// [R12] Voltage pulses separated by minimum rest
// [R13] Frequency pulse never longer than maximum
// [R14] Frequency pulse never shorter than minimum
// [R15] Frequency pulses separated by minimum rest
// [R16] Settings changes apply live without restart; sync_time_max_in is only loaded into time_left_out on start_in
// [R17] Report full slip rotation time estimate
// [R18] Report relative phase placement in degrees
// [R19] Report synchronizing time left, counting down
// [R20] Raise/lower from differences, length scaled
// [R21] Close only when all three differences ok
// [R22] Evaluate and time on 5 ms cycle
// [R23] Clamp pulse length between min and max
// [R24] Expiry flags long sync, drops running
module gsp_sync_ctrl #(
	parameter int TICK_CYCLES = `GSP_TICK_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic signed [31:0] mag_diff_in,
	input wire logic signed [31:0] freq_diff_in,
	input wire logic signed [31:0] ang_diff_in,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic get_errors_in,
	input wire logic [12:0] volt_max_in,
	input wire logic [7:0] freq_over_max_in,
	input wire logic [7:0] freq_under_max_in,
	input wire logic [11:0] ang_max_in,
	input wire gsp_pkg::gsp_ticks_t sync_time_max_in,
	input wire logic signed [31:0] volt_ofs_in,
	input wire logic signed [31:0] freq_ofs_in,
	input wire logic [11:0] volt_slope_in,
	input wire logic [11:0] freq_slope_in,
	input wire gsp_pkg::gsp_ticks_t volt_pulse_max_in,
	input wire gsp_pkg::gsp_ticks_t volt_pulse_min_in,
	input wire gsp_pkg::gsp_ticks_t volt_rest_min_in,
	input wire gsp_pkg::gsp_ticks_t freq_pulse_max_in,
	input wire gsp_pkg::gsp_ticks_t freq_pulse_min_in,
	input wire gsp_pkg::gsp_ticks_t freq_rest_min_in,
	output logic mag_ok_out,
	output logic freq_ok_out,
	output logic ang_ok_out,
	output logic running_out,
	output logic long_sync_out,
	output logic close_out,
	output logic volt_up_out,
	output logic volt_down_out,
	output logic freq_up_out,
	output logic freq_down_out,
	output gsp_pkg::gsp_ticks_t time_left_out,
	output gsp_pkg::gsp_ticks_t rot_time_out,
	output logic signed [31:0] placement_out,
	output logic signed [31:0] mag_tune_out,
	output logic signed [31:0] freq_tune_out,
	output logic signed [31:0] ang_tune_out
);
	import gsp_pkg::*;

	// ---------------------------------------------------------------
	// Processing cycle tick
	// ---------------------------------------------------------------
	logic [31:0] tick_cnt_q;
	logic tick_q;

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q >= 32'(TICK_CYCLES - 1))
		begin
			tick_cnt_q <= 32'h0000_0000; // R22
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Corrected differences and permissive checks
	// ---------------------------------------------------------------
	logic signed [31:0] mag_corr;
	logic signed [31:0] freq_corr;
	logic [31:0] mag_abs;
	logic [31:0] freq_abs;
	logic [31:0] ang_abs;
	logic mag_ok_d;
	logic freq_ok_d;
	logic ang_ok_d;

	assign mag_corr = mag_diff_in - volt_ofs_in; // R6
	assign freq_corr = freq_diff_in - freq_ofs_in; // R7
	assign mag_abs = mag_corr[31] ? 32'(-mag_corr) : 32'(mag_corr);
	assign freq_abs = freq_corr[31] ? 32'(-freq_corr) : 32'(freq_corr);
	assign ang_abs = ang_diff_in[31] ? 32'(-ang_diff_in) : 32'(ang_diff_in);

	// Compared against the live ports, so a setting group swap takes effect next cycle
	assign mag_ok_d = mag_abs <= 32'(volt_max_in) * `GSP_VOLT_SCALE; // R1 R16
	assign freq_ok_d = (freq_corr <= $signed(32'(freq_over_max_in) * `GSP_FREQ_SCALE)) // R2
		&& (-freq_corr <= $signed(32'(freq_under_max_in) * `GSP_FREQ_SCALE)); // R3
	assign ang_ok_d = ang_abs <= 32'(ang_max_in) * `GSP_ANG_SCALE; // R5

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mag_ok_out <= 1'b0;
			freq_ok_out <= 1'b0;
			ang_ok_out <= 1'b0;
		end
		else if (tick_q)
		begin
			mag_ok_out <= mag_ok_d; // R22
			freq_ok_out <= freq_ok_d;
			ang_ok_out <= ang_ok_d;
		end
	end

	// ---------------------------------------------------------------
	// Synchronizing attempt timer
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			running_out <= 1'b0;
			long_sync_out <= 1'b0;
			time_left_out <= '0;
		end
		else if (start_in)
		begin
			running_out <= 1'b1;
			long_sync_out <= 1'b0;
			time_left_out <= sync_time_max_in; // R19
		end
		else if (stop_in)
		begin
			running_out <= 1'b0;
		end
		else if (tick_q && running_out)
		begin
			if (time_left_out == '0)
			begin
				running_out <= 1'b0; // R4 R24
				long_sync_out <= 1'b1; // R24
			end
			else
			begin
				time_left_out <= time_left_out - 19'h0_0001; // R19
			end
		end
	end

	// ---------------------------------------------------------------
	// Close permission
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			close_out <= 1'b0;
		else if (tick_q)
			close_out <= running_out && mag_ok_d && freq_ok_d && ang_ok_d; // R21
	end

	// ---------------------------------------------------------------
	// Fine tune capture
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mag_tune_out <= 32'sh0000_0000;
			freq_tune_out <= 32'sh0000_0000;
			ang_tune_out <= 32'sh0000_0000;
		end
		else if (get_errors_in && mag_ok_out && freq_ok_out && ang_ok_out)
		begin
			// Raw values, so the capture can be written back as an offset
			mag_tune_out <= mag_diff_in; // R8
			freq_tune_out <= freq_diff_in;
			ang_tune_out <= ang_diff_in;
		end
	end

	// ---------------------------------------------------------------
	// Rotation time and phase placement
	// ---------------------------------------------------------------
	logic [31:0] rot_quot;

	assign rot_quot = (freq_abs == 32'h0000_0000) ? 32'(`GSP_ROT_SAT) : `GSP_ROT_NUM / freq_abs;

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rot_time_out <= '0;
			placement_out <= 32'sh0000_0000;
		end
		else if (tick_q)
		begin
			// Saturates at the 360 s display range when slip is tiny
			if (rot_quot > 32'(`GSP_ROT_SAT))
				rot_time_out <= `GSP_ROT_SAT; // R17
			else
				rot_time_out <= rot_quot[18:0]; // R17
			placement_out <= ang_diff_in; // R18
		end
	end

	// ---------------------------------------------------------------
	// Pulse length: twice the error over slope, clamped
	// ---------------------------------------------------------------
	function automatic gsp_ticks_t pulse_len(
		input logic [31:0] err,
		input logic [11:0] slope,
		input gsp_ticks_t mn,
		input gsp_ticks_t mx
	);
		logic [32:0] raw;
		raw = 33'h0_0000_0000;
		// Zero slope means an infinitely slow regulator: use the longest pulse
		if (slope == 12'h000)
			raw = {14'h0000, mx};
		else
			raw = {err, 1'b0} / {21'h00_0000, slope}; // R9 R20
		if (raw < {14'h0000, mn})
			raw = {14'h0000, mn}; // R23
		if (raw > {14'h0000, mx})
			raw = {14'h0000, mx}; // R23
		return raw[18:0];
	endfunction : pulse_len

	// ---------------------------------------------------------------
	// Raise/lower channels: 0 voltage, 1 frequency
	// ---------------------------------------------------------------
	logic [1:0] ch_ok;
	logic [1:0] ch_neg;
	logic [31:0] ch_err [2];
	logic [11:0] ch_slope [2];
	gsp_ticks_t ch_max [2];
	gsp_ticks_t ch_min [2];
	gsp_ticks_t ch_rest [2];
	logic [1:0] up_q;
	logic [1:0] down_q;

	assign ch_ok = {freq_ok_d, mag_ok_d};
	assign ch_neg = {freq_corr[31], mag_corr[31]};
	assign ch_err[0] = mag_abs;
	assign ch_err[1] = freq_abs;
	assign ch_slope[0] = volt_slope_in;
	assign ch_slope[1] = freq_slope_in;
	assign ch_max[0] = volt_pulse_max_in;
	assign ch_max[1] = freq_pulse_max_in;
	assign ch_min[0] = volt_pulse_min_in;
	assign ch_min[1] = freq_pulse_min_in;
	assign ch_rest[0] = volt_rest_min_in;
	assign ch_rest[1] = freq_rest_min_in;

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		gsp_pulse_st_t st_q;
		gsp_ticks_t cnt_q;
		gsp_ticks_t len_q;

		always_ff @(posedge core_clk_in or negedge rst_b_in)
		begin
			if (!rst_b_in)
			begin
				st_q <= GSP_IDLE;
				cnt_q <= '0;
				len_q <= '0;
				up_q[ch] <= 1'b0;
				down_q[ch] <= 1'b0;
			end
			else if (tick_q)
			begin
				unique case (st_q)
					GSP_IDLE:
					begin
						if (running_out && !ch_ok[ch])
						begin
							// Drive against the sign of the difference
							up_q[ch] <= ch_neg[ch]; // R20
							down_q[ch] <= !ch_neg[ch]; // R20
							len_q <= pulse_len(ch_err[ch], ch_slope[ch], ch_min[ch], ch_max[ch]); // R23
							cnt_q <= 19'h0_0001;
							st_q <= GSP_PULSE;
						end
					end
					GSP_PULSE:
					begin
						// Live max cuts short, live min extends; max wins a conflict
						if ((cnt_q >= len_q && cnt_q >= ch_min[ch]) || cnt_q >= ch_max[ch]) // R10 R11 R13 R14 R16
						begin
							up_q[ch] <= 1'b0;
							down_q[ch] <= 1'b0;
							cnt_q <= 19'h0_0001;
							st_q <= GSP_REST;
						end
						else
						begin
							cnt_q <= cnt_q + 19'h0_0001;
						end
					end
					GSP_REST:
					begin
						if (cnt_q >= ch_rest[ch]) // R12 R15
							st_q <= GSP_IDLE;
						else
							cnt_q <= cnt_q + 19'h0_0001;
					end
					default:
					begin
						st_q <= GSP_IDLE;
						up_q[ch] <= 1'b0;
						down_q[ch] <= 1'b0;
					end
				endcase
			end
		end
	end

	assign volt_up_out = up_q[0];
	assign volt_down_out = down_q[0];
	assign freq_up_out = up_q[1];
	assign freq_down_out = down_q[1];

endmodule : gsp_sync_ctrl

`default_nettype wire

// File: verif/gsp_gen_model.sv
/* Regulator and governor model: integrates raise/lower pulses into
   the differences. Loaded by the bench; shares its clock. */
`timescale 1ns/100ps
`default_nettype none
module gsp_gen_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic load_in,
	input wire logic signed [31:0] mag_init_in,
	input wire logic signed [31:0] freq_init_in,
	input wire logic volt_up_in,
	input wire logic volt_down_in,
	input wire logic freq_up_in,
	input wire logic freq_down_in,
	output logic signed [31:0] mag_out,
	output logic signed [31:0] freq_out
);
	// Slow drift, so one pulse never closes the gap alone
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mag_out <= '0;
			freq_out <= '0;
		end
		else if (load_in)
		begin
			mag_out <= mag_init_in;
			freq_out <= freq_init_in;
		end
		else
		begin
			mag_out <= mag_out + 32'(volt_up_in) - 32'(volt_down_in);
			freq_out <= freq_out + 32'(freq_up_in) - 32'(freq_down_in);
		end
	end
endmodule : gsp_gen_model
`default_nettype wire

// File: verif/gsp_sync_ctrl_sva.sv
/* Checker of the synchronizer pulse controller.
   Bound to its top module; sees only that module's ports. */
`timescale 1ns/100ps
`default_nettype none
module gsp_sync_ctrl_sva #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire logic get_errors_in,
	input wire logic signed [31:0] mag_diff_in,
	input wire gsp_pkg::gsp_ticks_t volt_pulse_max_in,
	input wire gsp_pkg::gsp_ticks_t volt_pulse_min_in,
	input wire gsp_pkg::gsp_ticks_t volt_rest_min_in,
	input wire gsp_pkg::gsp_ticks_t freq_pulse_max_in,
	input wire logic mag_ok_out,
	input wire logic freq_ok_out,
	input wire logic ang_ok_out,
	input wire logic running_out,
	input wire logic long_sync_out,
	input wire logic close_out,
	input wire logic volt_up_out,
	input wire logic volt_down_out,
	input wire logic freq_up_out,
	input wire logic freq_down_out,
	input wire gsp_pkg::gsp_ticks_t time_left_out,
	input wire logic signed [31:0] mag_tune_out
);
	import gsp_pkg::*;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	logic vp;
	logic fp;
	int vc_q;
	int vg_q;
	int fc_q;
	assign vp = volt_up_out | volt_down_out;
	assign fp = freq_up_out | freq_down_out;
	// Gap starts high: the first pulse has no predecessor
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			vc_q <= '0;
			fc_q <= '0;
			vg_q <= 32'h0FFF_FFFF;
		end
		else
		begin
			vc_q <= vp ? vc_q + 1 : '0;
			fc_q <= fp ? fc_q + 1 : '0;
			vg_q <= vp ? '0 : vg_q + 1;
		end
	end
	property p_vmax;
		$fell(vp) |-> vc_q <= int'(volt_pulse_max_in) * TICK_CYCLES;
	endproperty
	a_vmax: assert property (p_vmax) else $error("voltage pulse too long");
	property p_vmin;
		$fell(vp) |-> vc_q >= int'(volt_pulse_min_in) * TICK_CYCLES;
	endproperty
	a_vmin: assert property (p_vmin) else $error("voltage pulse too short");
	property p_vrest;
		$rose(vp) |-> vg_q >= int'(volt_rest_min_in) * TICK_CYCLES;
	endproperty
	a_vrest: assert property (p_vrest) else $error("voltage rest too short");
	property p_fmax;
		$fell(fp) |-> fc_q <= int'(freq_pulse_max_in) * TICK_CYCLES;
	endproperty
	a_fmax: assert property (p_fmax) else $error("frequency pulse too long");
	property p_close;
		close_out |-> mag_ok_out && freq_ok_out && ang_ok_out;
	endproperty
	a_close: assert property (p_close) else $error("close without all checks");
	property p_expire;
		running_out && time_left_out == '0 && !start_in |-> ##[1:TICK_CYCLES] !running_out;
	endproperty
	a_expire: assert property (p_expire) else $error("attempt not cancelled");
	property p_long;
		$rose(long_sync_out) |-> !running_out;
	endproperty
	a_long: assert property (p_long) else $error("long sync while running");
	property p_left;
		running_out && $past(running_out) && !$past(start_in) && time_left_out != $past(time_left_out)
			|-> time_left_out == $past(time_left_out) - 19'h0_0001;
	endproperty
	a_left: assert property (p_left) else $error("time left not counting down");
	property p_tune;
		get_errors_in && mag_ok_out && freq_ok_out && ang_ok_out |=> mag_tune_out == $past(mag_diff_in);
	endproperty
	a_tune: assert property (p_tune) else $error("tune value not captured");
endmodule : gsp_sync_ctrl_sva
`default_nettype wire

// File: verif/gsp_sync_ctrl_tb_top.sv
/* Testbench of the synchronizer pulse controller and its generator model.
   Assumes design, package, checker and model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "gsp_consts.svh"
module gsp_sync_ctrl_tb_top;
	import gsp_pkg::*;
	localparam int TK = 10;
	typedef struct {
		logic signed [31:0] m, o, f, a;
		logic [2:0] ok;
		gsp_ticks_t r;
	} gsp_row_t;
	gsp_row_t rows [4];
	logic core_clk_in, rst_b_in, start_in, stop_in, get_errors_in, load;
	logic signed [31:0] mag_diff_in, freq_diff_in, ang_diff_in, volt_ofs_in, freq_ofs_in, mag_init, freq_init;
	logic [11:0] volt_slope_in;
	gsp_ticks_t sync_time_max_in, pmax, pmin, rmin, time_left_out, rot_time_out;
	logic mag_ok_out, freq_ok_out, ang_ok_out, running_out, long_sync_out, close_out;
	logic volt_up_out, volt_down_out, freq_up_out, freq_down_out;
	logic signed [31:0] placement_out, mag_tune_out, freq_tune_out, ang_tune_out;
	int failures, check_count, len, gap;
	gsp_sync_ctrl #(.TICK_CYCLES(TK)) i_gsp_sync_ctrl (
		.core_clk_in, .rst_b_in, .mag_diff_in, .freq_diff_in, .ang_diff_in, .start_in, .stop_in, .get_errors_in,
		.volt_max_in(`GSP_DEF_VOLT_MAX), .freq_over_max_in(`GSP_DEF_FREQ_OVER),
		.freq_under_max_in(`GSP_DEF_FREQ_UNDER), .ang_max_in(`GSP_DEF_ANG_MAX),
		.sync_time_max_in, .volt_ofs_in, .freq_ofs_in, .volt_slope_in, .freq_slope_in(12'h3E8),
		.volt_pulse_max_in(pmax), .volt_pulse_min_in(pmin), .volt_rest_min_in(rmin),
		.freq_pulse_max_in(pmax), .freq_pulse_min_in(pmin), .freq_rest_min_in(rmin),
		.mag_ok_out, .freq_ok_out, .ang_ok_out, .running_out, .long_sync_out, .close_out, .volt_up_out,
		.volt_down_out, .freq_up_out, .freq_down_out, .time_left_out, .rot_time_out, .placement_out,
		.mag_tune_out, .freq_tune_out, .ang_tune_out);
	gsp_gen_model i_gsp_gen_model (.clk_in(core_clk_in), .rst_b_in, .load_in(load), .mag_init_in(mag_init),
		.freq_init_in(freq_init), .volt_up_in(volt_up_out), .volt_down_in(volt_down_out),
		.freq_up_in(freq_up_out), .freq_down_in(freq_down_out), .mag_out(mag_diff_in), .freq_out(freq_diff_in));
	always #20 core_clk_in = ~core_clk_in;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		if (failures == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic step(inout int n);
		@(posedge core_clk_in);
		#1;
		n++;
		if (n > 2000)
		begin
			failures++;
			$display("ERROR %0t wait ran out", $time);
			print_verdict();
		end
	endtask : step
	// Length of the next pulse and of the gap after it, in clocks
	task automatic measure(ref logic s);
		int n;
		n = 0;
		len = 0;
		gap = 0;
		while (s !== 1'b1)
			step(n);
		while (s === 1'b1)
			step(len);
		while (s !== 1'b1)
			step(gap);
	endtask : measure
	task automatic set_meas(input logic signed [31:0] m, f, a, o);
		@(posedge core_clk_in);
		load <= 1'b1;
		mag_init <= m;
		freq_init <= f;
		ang_diff_in <= a;
		volt_ofs_in <= o;
		@(posedge core_clk_in);
		load <= 1'b0;
	endtask : set_meas
	initial
	begin
		rows[0] = '{32'sh0000_4E20, '0, 32'sh0000_03E8, 32'sh0000_2710, 3'b111, 19'h0_03E8};
		rows[1] = '{32'sh0000_4E21, '0, 32'sh0000_03E9, 32'shFFFF_D8EF, 3'b000, 19'h0_03E7};
		rows[2] = '{32'shFFFF_B1DF, '0, 32'shFFFF_FC17, '0, 3'b001, 19'h1_1940};
		rows[3] = '{32'sh0000_61A8, 32'sh0000_1388, 32'shFFFF_FC18, 32'shFFFF_D8F0, 3'b111, 19'h1_1940};
		{core_clk_in, rst_b_in, start_in, stop_in, get_errors_in, load} = '0;
		{mag_init, freq_init, ang_diff_in, volt_ofs_in} = '0;
		freq_ofs_in = `GSP_DEF_FREQ_OFS;
		volt_slope_in = `GSP_DEF_VOLT_SLOPE;
		sync_time_max_in = 19'h0_0064;
		pmax = `GSP_DEF_PULSE_MAX;
		pmin = `GSP_DEF_PULSE_MIN;
		rmin = `GSP_DEF_REST_MIN;
		failures = 0;
		check_count = 0;
		repeat (12) @(posedge core_clk_in);
		#1;
		chk({running_out, close_out, volt_up_out, freq_down_out}, '0);
		@(posedge core_clk_in);
		rst_b_in <= 1'b1;
		foreach (rows[i])
		begin
			set_meas(rows[i].m, rows[i].f, rows[i].a, rows[i].o);
			repeat (TK + 1) @(posedge core_clk_in);
			#1;
			chk({mag_ok_out, freq_ok_out, ang_ok_out}, rows[i].ok);
			chk(rot_time_out, rows[i].r);
			chk(placement_out, rows[i].a);
			chk(close_out, 1'b0);
		end
		@(posedge core_clk_in);
		start_in <= 1'b1;
		@(posedge core_clk_in);
		start_in <= 1'b0;
		#1;
		chk(time_left_out, 19'h0_0064);
		repeat (TK) @(posedge core_clk_in);
		#1;
		chk(close_out, 1'b1);
		@(posedge core_clk_in);
		get_errors_in <= 1'b1;
		@(posedge core_clk_in);
		get_errors_in <= 1'b0;
		#1;
		chk(ang_tune_out, 32'shFFFF_D8F0);
		@(posedge core_clk_in);
		pmax <= 19'h0_0014;
		pmin <= 19'h0_0002;
		rmin <= 19'h0_0003;
		volt_slope_in <= 12'hFA0;
		// Error 30000 at slope 4000 gives 15 ticks
		set_meas(32'shFFFF_8AD0, 32'shFFFF_FC18, '0, '0);
		measure(volt_up_out);
		chk(len, 15 * TK);
		chk(gap, (3 + 1) * TK);
		set_meas('0, 32'sh0000_0FA0, '0, '0);
		measure(freq_down_out);
		chk(len, 10 * TK);
		chk(gap, (3 + 1) * TK);
		@(posedge core_clk_in);
		stop_in <= 1'b1;
		sync_time_max_in <= 19'h0_0002;
		@(posedge core_clk_in);
		stop_in <= 1'b0;
		start_in <= 1'b1;
		#1;
		chk(running_out, 1'b0);
		@(posedge core_clk_in);
		start_in <= 1'b0;
		repeat (4 * TK) @(posedge core_clk_in);
		#1;
		chk({long_sync_out, running_out}, 2'b10);
		print_verdict();
	end
endmodule : gsp_sync_ctrl_tb_top
bind gsp_sync_ctrl gsp_sync_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) i_gsp_sync_ctrl_sva (.core_clk_in, .rst_b_in,
	.start_in, .get_errors_in, .mag_diff_in, .volt_pulse_max_in, .volt_pulse_min_in, .volt_rest_min_in,
	.freq_pulse_max_in, .mag_ok_out, .freq_ok_out, .ang_ok_out, .running_out, .long_sync_out, .close_out,
	.volt_up_out, .volt_down_out, .freq_up_out, .freq_down_out, .time_left_out, .mag_tune_out);
`default_nettype wire
